// ### inc/jaef_pkg.sv
// package: constants and types of the elastic jitter buffer
package jaef_pkg;
   localparam int FIFO_DEPTH = 16;
   localparam int PTR_W = 4;
   localparam int ADDR_W = 8;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_INT_STAT = 8'h08;
   localparam logic [7:0] ADDR_INT_MASK = 8'h0C;
   localparam logic [7:0] ADDR_PULL = 8'h10;
   localparam int CTRL_ALT_BIT = 0;
   localparam int CTRL_PRST_BIT = 1;
   localparam int CTRL_SCLR_BIT = 2;
   localparam int STAT_SLIP_BIT = 8;
   localparam int STAT_ALT_BIT = 9;
   localparam logic CTRL_ALT_RESET = 1'h0;
   localparam logic [1:0] MASK_RESET = 2'h0;
   localparam logic [15:0] NCO_NOMINAL = 16'h8000;
   localparam int PULL_SHIFT = 4;
   localparam logic [1:0] OSC_DIV_LAST = 2'h3;
   typedef struct packed {
      logic slip_rst_n;
      logic ptr_rst_n;
      logic alt_clk;
      logic line_data;
      logic line_clk;
   } jaef_pins_t;
   typedef struct packed {
      logic unf;
      logic ovf;
   } jaef_flags_t;
endpackage

// ### rtl/jaef_sync.sv
// two-flop synchroniser with edge detection
`timescale 1ns/100ps
module jaef_sync #(
   parameter int W = 5
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] level,
   output logic [W-1:0] rise,
   output logic [W-1:0] fall
);
   logic [W-1:0] s1_reg, s2_reg, s3_reg;
   logic [W-1:0] s1_next, s2_next, s3_next;

   always_comb begin
      s1_next = async_in;
      s2_next = s1_reg;
      s3_next = s2_reg;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
      end else begin
         s1_reg <= s1_next;
         s2_reg <= s2_next;
         s3_reg <= s3_next;
      end
   end

   assign level = s2_reg;
   assign rise = s2_reg & ~s3_reg;
   assign fall = ~s2_reg & s3_reg;
endmodule

// ### rtl/jaef_osc.sv
// pullable numeric oscillator with divide-by-four read clock
`timescale 1ns/100ps
module jaef_osc (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic signed [15:0] pull,
   output logic read_clk,
   output logic read_fall
);
   logic [15:0] acc_reg, acc_next;
   logic [1:0] div_reg, div_next;
   logic [16:0] sum;
   logic tick;

   // faster oscillator when pull is positive
   assign sum = {1'b0, acc_reg} + {1'b0, jaef_pkg::NCO_NOMINAL} + 17'(pull);
   assign tick = sum[16];

   always_comb begin
      acc_next = sum[15:0];
      div_next = div_reg;
      if (tick) begin
         div_next = div_reg + 2'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_reg <= '0;
         div_reg <= '0;
      end else begin
         acc_reg <= acc_next;
         div_reg <= div_next;
      end
   end

   assign read_clk = div_reg[1];
   assign read_fall = tick && (div_reg == jaef_pkg::OSC_DIV_LAST);
endmodule

// ### rtl/jaef_top.sv
// elastic jitter buffer with apb registers
//
// The APB register port and the address map were decided locally.
`timescale 1ns/100ps
module jaef_top #(
   parameter int DEPTH = jaef_pkg::FIFO_DEPTH,
   parameter int PW = jaef_pkg::PTR_W
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [jaef_pkg::ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic line_input_clock,
   input wire logic line_data,
   input wire logic alt_read_clock,
   input wire logic pointer_reset_n,
   input wire logic slip_reset_n,
   output logic dejittered_clock,
   output logic line_data_out,
   output logic slip_error_flag,
   output logic [15:0] osc_pull,
   output logic irq
);
   localparam logic [PW:0] FULL_LVL = (PW+1)'(DEPTH);
   localparam logic [PW:0] HALF_LVL = (PW+1)'(DEPTH / 2);

   // pin synchronisers

   jaef_pkg::jaef_pins_t pins_in;
   jaef_pkg::jaef_pins_t pins_lvl;
   jaef_pkg::jaef_pins_t pins_fall;

   assign pins_in.slip_rst_n = slip_reset_n;
   assign pins_in.ptr_rst_n = pointer_reset_n;
   assign pins_in.alt_clk = alt_read_clock;
   assign pins_in.line_data = line_data;
   assign pins_in.line_clk = line_input_clock;

   jaef_sync #(
      .W($bits(jaef_pkg::jaef_pins_t))
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(pins_in),
      .level(pins_lvl),
      .rise(),
      .fall(pins_fall)
   );

   // oscillator

   logic signed [15:0] pull_reg, pull_next;
   logic osc_clk;
   logic osc_fall;

   jaef_osc u_osc (
      .pclk(pclk),
      .presetn(presetn),
      .pull(pull_reg),
      .read_clk(osc_clk),
      .read_fall(osc_fall)
   );

   // register state

   logic ctrl_alt_reg, ctrl_alt_next;
   logic soft_prst_reg, soft_prst_next;
   logic soft_sclr_reg, soft_sclr_next;
   jaef_pkg::jaef_flags_t int_reg, int_next;
   jaef_pkg::jaef_flags_t mask_reg, mask_next;
   logic [31:0] prdata_reg, prdata_next;
   logic pready_reg, pready_next;
   logic pslverr_reg, pslverr_next;
   logic irq_reg, irq_next;

   // fifo state

   logic [PW:0] wr_ptr_reg, wr_ptr_next;
   logic [PW:0] rd_ptr_reg, rd_ptr_next;
   logic dout_reg, dout_next;
   logic slip_reg, slip_next;
   logic dclk_reg, dclk_next;
   logic mem_reg [DEPTH];
   logic mem_we;

   logic [PW:0] level;
   logic signed [PW+1:0] sep_err;
   logic full, empty;
   logic wr_evt, rd_evt;
   logic rd_clk_lvl;
   logic ptr_rst, slip_clr;
   jaef_pkg::jaef_flags_t evt;

   // read source select

   // the select only moves while both candidate clocks are low, so the
   // output clock never shows a runt pulse when software changes source
   logic alt_act_reg, alt_act_next;
   // osc fall event delayed one cycle, so it meets the low osc level
   // just as a synchronised alt clock fall does
   logic osc_fall_reg, osc_fall_next;

   always_comb begin
      alt_act_next = alt_act_reg;
      osc_fall_next = osc_fall;
      if ((ctrl_alt_reg != alt_act_reg) && !osc_clk && !pins_lvl.alt_clk) begin
         alt_act_next = ctrl_alt_reg;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alt_act_reg <= jaef_pkg::CTRL_ALT_RESET;
         osc_fall_reg <= 1'b0;
      end else begin
         alt_act_reg <= alt_act_next;
         osc_fall_reg <= osc_fall_next;
      end
   end

   // read clock source, data moves on the edge where the clock falls
   assign rd_clk_lvl = alt_act_reg ? pins_lvl.alt_clk : osc_clk;
   assign rd_evt = alt_act_reg ? pins_fall.alt_clk : osc_fall_reg;
   assign wr_evt = pins_fall.line_clk;

   assign ptr_rst = !pins_lvl.ptr_rst_n || soft_prst_reg;
   assign slip_clr = !pins_lvl.slip_rst_n || soft_sclr_reg;

   assign level = wr_ptr_reg - rd_ptr_reg;
   assign full = (level == FULL_LVL);
   assign empty = (level == '0);
   assign sep_err = $signed({1'b0, level}) - $signed({1'b0, HALF_LVL});

   always_comb begin
      wr_ptr_next = wr_ptr_reg;
      rd_ptr_next = rd_ptr_reg;
      dout_next = dout_reg;
      slip_next = slip_reg;
      dclk_next = rd_clk_lvl;
      evt = '0;
      mem_we = 1'b0;
      if (ptr_rst) begin
         // restart half full, buffered bits are lost
         wr_ptr_next = HALF_LVL;
         rd_ptr_next = '0;
      end else begin
         if (wr_evt) begin
            if (full && !rd_evt) begin
               evt.ovf = 1'b1;
            end else begin
               mem_we = 1'b1;
               wr_ptr_next = wr_ptr_reg + 1'b1;
            end
         end
         if (rd_evt) begin
            if (empty) begin
               evt.unf = 1'b1;
            end else begin
               // changes on read clock fall, steady at its rise
               dout_next = mem_reg[rd_ptr_reg[PW-1:0]];
               rd_ptr_next = rd_ptr_reg + 1'b1;
            end
         end
      end
      // set wins over clear
      if (evt.ovf || evt.unf) begin
         slip_next = 1'b1;
      end else if (slip_clr) begin
         slip_next = 1'b0;
      end
      // more data than centre speeds the read side
      pull_next = 16'(sep_err) <<< jaef_pkg::PULL_SHIFT;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr_reg <= HALF_LVL;
         rd_ptr_reg <= '0;
         dout_reg <= 1'b0;
         slip_reg <= 1'b0;
         dclk_reg <= 1'b0;
         pull_reg <= '0;
      end else begin
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
         dout_reg <= dout_next;
         slip_reg <= slip_next;
         dclk_reg <= dclk_next;
         pull_reg <= pull_next;
      end
   end

   // storage, no reset needed
   always_ff @(posedge pclk) begin
      if (mem_we) begin
         mem_reg[wr_ptr_reg[PW-1:0]] <= pins_lvl.line_data;
      end
   end

   // apb slave, one wait state

   logic acc_phase;
   logic wr_fire;
   logic mapped;
   logic [31:0] rd_word;

   assign acc_phase = psel && penable && !pready_reg;
   assign wr_fire = psel && penable && pready_reg && pwrite;

   always_comb begin
      mapped = 1'b1;
      rd_word = '0;
      unique case (paddr)
         jaef_pkg::ADDR_CTRL: begin
            rd_word[jaef_pkg::CTRL_ALT_BIT] = ctrl_alt_reg;
         end
         jaef_pkg::ADDR_STATUS: begin
            rd_word[PW:0] = level;
            rd_word[jaef_pkg::STAT_SLIP_BIT] = slip_reg;
            rd_word[jaef_pkg::STAT_ALT_BIT] = ctrl_alt_reg;
         end
         jaef_pkg::ADDR_INT_STAT: begin
            rd_word[1:0] = int_reg;
         end
         jaef_pkg::ADDR_INT_MASK: begin
            rd_word[1:0] = mask_reg;
         end
         jaef_pkg::ADDR_PULL: begin
            rd_word = 32'(pull_reg);
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   always_comb begin
      ctrl_alt_next = ctrl_alt_reg;
      mask_next = mask_reg;
      soft_prst_next = 1'b0;
      soft_sclr_next = 1'b0;
      int_next = int_reg | evt;
      pready_next = acc_phase;
      pslverr_next = acc_phase && !mapped;
      prdata_next = '0;
      if (acc_phase && !pwrite) begin
         prdata_next = rd_word;
      end
      if (wr_fire) begin
         unique case (paddr)
            jaef_pkg::ADDR_CTRL: begin
               ctrl_alt_next = pwdata[jaef_pkg::CTRL_ALT_BIT];
               soft_prst_next = pwdata[jaef_pkg::CTRL_PRST_BIT];
               soft_sclr_next = pwdata[jaef_pkg::CTRL_SCLR_BIT];
            end
            jaef_pkg::ADDR_INT_STAT: begin
               // write one to clear, new events still land
               int_next = (int_reg & ~pwdata[1:0]) | evt;
            end
            jaef_pkg::ADDR_INT_MASK: begin
               mask_next = pwdata[1:0];
            end
            default: begin
               ctrl_alt_next = ctrl_alt_reg;
            end
         endcase
      end
      irq_next = |(int_next & mask_next);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_alt_reg <= jaef_pkg::CTRL_ALT_RESET;
         mask_reg <= jaef_pkg::MASK_RESET;
         int_reg <= '0;
         soft_prst_reg <= 1'b0;
         soft_sclr_reg <= 1'b0;
         prdata_reg <= '0;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else begin
         ctrl_alt_reg <= ctrl_alt_next;
         mask_reg <= mask_next;
         int_reg <= int_next;
         soft_prst_reg <= soft_prst_next;
         soft_sclr_reg <= soft_sclr_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         irq_reg <= irq_next;
      end
   end

   // outputs

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign dejittered_clock = dclk_reg;
   assign line_data_out = dout_reg;
   assign slip_error_flag = slip_reg;
   assign osc_pull = pull_reg;
   assign irq = irq_reg;
endmodule

// ### test/jaef_line_rx.sv
// line receiver model: recovered line clock and data
`timescale 1ns/100ps
module jaef_line_rx (
   input wire logic run,
   input wire logic [9:0] half_ns,
   input wire logic bit_in,
   output logic line_clk,
   output logic line_dat
);
   initial begin
      line_clk = 1'b0;
      line_dat = 1'b0;
      forever begin
         if (run) begin
            #(half_ns) line_clk = 1'b1;
            line_dat = bit_in; // steady through the fall
            #(half_ns) line_clk = 1'b0;
         end else begin
            #(half_ns) line_dat = ~line_dat; // clock still, data not held
         end
      end
   end
endmodule

// ### test/jaef_top_sva.sv
// checker: port properties of the elastic jitter buffer
`timescale 1ns/100ps
module jaef_top_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] prdata,
   input wire logic slip_reset_n,
   input wire logic dejittered_clock,
   input wire logic line_data_out,
   input wire logic slip_error_flag,
   input wire logic [15:0] osc_pull,
   input wire logic irq
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
      else $error("ready not one cycle after access");
   a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
   a_err_with_ready: assert property (pslverr |-> pready) else $error("stray slverr");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("rdata idle");
   a_slip_sticky: assert property (slip_error_flag && slip_reset_n && $past(slip_reset_n)
      && $past(slip_reset_n, 2) && $past(slip_reset_n, 3) && !psel && !$past(psel)
      && !$past(psel, 2) && !$past(psel, 3) |=> slip_error_flag) else $error("slip dropped");
   a_pull_steps: assert property (osc_pull[3:0] == 4'h0
      && (osc_pull[15:11] == 5'h00 || osc_pull[15:11] == 5'h1F)) else $error("pull step");
   a_clk_high: assert property ($rose(dejittered_clock) |-> dejittered_clock[*3])
      else $error("short clock high");
   a_data_at_rise: assert property ($rose(dejittered_clock) |-> $stable(line_data_out))
      else $error("data moved at rise");
   a_data_at_fall: assert property ($changed(line_data_out) |-> $fell(dejittered_clock))
      else $error("data moved off fall");
   c_slip: cover property ($rose(slip_error_flag));
   c_slverr: cover property (pslverr);
   c_irq: cover property ($rose(irq));
endmodule
bind jaef_top jaef_top_chk u_jaef_top_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata),
   .slip_reset_n(slip_reset_n), .dejittered_clock(dejittered_clock),
   .line_data_out(line_data_out), .slip_error_flag(slip_error_flag), .osc_pull(osc_pull),
   .irq(irq));

// ### test/tb_top.sv
// testbench: elastic jitter buffer over apb with a line receiver model
`timescale 1ns/100ps
module tb_top;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic lclk, ldat, alt_clk, prst_n, srst_n, dclk, dout, slip, irq, run, bit_in, alt_run;
   logic [7:0] paddr, seed;
   logic [31:0] pwdata, prdata;
   logic [15:0] pull;
   logic [9:0] half;
   logic [32:0] exp_q[$], msk_q[$], e_cur, m_cur;
   int fails, comparisons, cnt;
   jaef_top u_jaef_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .line_input_clock(lclk), .line_data(ldat), .alt_read_clock(alt_clk),
      .pointer_reset_n(prst_n), .slip_reset_n(srst_n), .dejittered_clock(dclk),
      .line_data_out(dout), .slip_error_flag(slip), .osc_pull(pull), .irq(irq));
   jaef_line_rx u_jaef_line_rx (.run(run), .half_ns(half), .bit_in(bit_in), .line_clk(lclk),
      .line_dat(ldat));
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic complete_run();
      if (fails == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input string nm, input logic [32:0] ex, input logic [32:0] got);
      comparisons++;
      if (got !== ex) begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [32:0] e, input logic [32:0] m);
      int n;
      exp_q.push_back(e & m);
      msk_q.push_back(m);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n == 20) begin
         fails++;
         complete_run();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, '0, '1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
      apb(1'b0, a, '0, e, m);
   endtask
   task automatic pulse_resets();
      @(posedge pclk);
      prst_n <= 1'b0; // shared pointer reset, flags after
      repeat (3) @(posedge pclk);
      prst_n <= 1'b1;
      srst_n <= 1'b0;
      repeat (3) @(posedge pclk);
      srst_n <= 1'b1;
   endtask
   task automatic count_rises(input int cyc);
      logic prev;
      cnt = 0;
      prev = dclk;
      repeat (cyc) begin
         @(posedge pclk);
         if (dclk && !prev)
            cnt++;
         prev = dclk;
      end
   endtask
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   initial begin
      alt_clk = 1'b0;
      forever begin
         #240;
         alt_clk = alt_run ? ~alt_clk : 1'b0; // stands for master output
      end
   end
   always @(posedge pclk) begin
      seed <= lfsr(seed);
      bit_in <= seed[0];
      if (pready === 1'b1) begin
         e_cur = exp_q.pop_front();
         m_cur = msk_q.pop_front();
         check("apb word", e_cur, {pslverr, prdata} & m_cur);
      end
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, bit_in, alt_run} = '0;
      {prst_n, srst_n, run} = 3'h7;
      half = 10'h0A0; // line at operating rate
      seed = 8'h57;
      fails = 0;
      comparisons = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rd(jaef_pkg::ADDR_CTRL, '0, '1);
      wr(jaef_pkg::ADDR_INT_MASK, 32'h3);
      rd(jaef_pkg::ADDR_INT_MASK, 33'h3, '1);
      pulse_resets();
      wr(jaef_pkg::ADDR_INT_STAT, 32'h3);
      repeat (400) @(posedge pclk);
      rd(jaef_pkg::ADDR_STATUS, '0, 33'h300);
      rd(jaef_pkg::ADDR_INT_STAT, '0, '1);
      rd(jaef_pkg::ADDR_PULL, '0, 33'hF);
      check("irq", '0, irq);
      count_rises(240);
      check("osc read clock", 33'h1, cnt >= 29 && cnt <= 31);
      run <= 1'b0;
      repeat (200) @(posedge pclk);
      rd(jaef_pkg::ADDR_INT_STAT, 33'h2, 33'h2);
      rd(jaef_pkg::ADDR_PULL, 33'hFFFFFF80, '1);
      check("irq", 33'h1, irq);
      run <= 1'b1; // line clock runs again
      repeat (200) @(posedge pclk);
      rd(jaef_pkg::ADDR_STATUS, 33'h100, 33'h100);
      wr(jaef_pkg::ADDR_INT_MASK, 32'h0);
      repeat (2) @(posedge pclk);
      check("irq", '0, irq);
      pulse_resets();
      wr(jaef_pkg::ADDR_INT_STAT, 32'h3);
      repeat (100) @(posedge pclk);
      rd(jaef_pkg::ADDR_STATUS, '0, 33'h100);
      half <= 10'h078;
      repeat (500) @(posedge pclk);
      rd(jaef_pkg::ADDR_INT_STAT, 33'h1, 33'h1);
      half <= 10'h0A0;
      alt_run <= 1'b1;
      wr(jaef_pkg::ADDR_CTRL, 32'h1);
      rd(jaef_pkg::ADDR_STATUS, 33'h200, 33'h200);
      count_rises(240);
      check("alt read clock", 33'h1, cnt >= 19 && cnt <= 21);
      rd(8'h14, 33'h100000000, '1);
      complete_run();
   end
endmodule
